// ==== rtl/tlccc_ctrl.sv ====
// coherency state control for split l1 caches and a unified l2 cache
// assumes the bus side answers each request with one bus_ack_in pulse
//
// How it works
// - internal snoop invalidates l1; dirty data to l2/bus
// - every bus writeback is a 32-byte burst
// - instruction cache holds one valid state only
// - never l1 data exclusive with l2 modified
// - writethrough goes out as one single cycle
// - write after modification is a writeback
// - writebacks are bursts, never single transfers
// - shared or invalid lines behave writethrough
// - modified or exclusive lines behave writeback
// - address-bit-20 mask sampled as a level
// - mask applied on the tag path
// - line fills use the masked address
// - writethroughs use the masked address
// - snoop, flush, page, maintenance writebacks bypass mask
// - flush pin writes back dirty lines, invalidates all
// - page flush writes back, page invalidate does not
// - writeback-invalidate flushes; invalidate-all just invalidates
// - l1 caches snoop each other, never l2
`include "tlccc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tlccc_ctrl #(
   parameter int LINES = `TLCCC_LINES
) (
   input  wire logic                    ref_clk_in,
   input  wire logic                    rst_in,
   input  wire logic                    ce_in,
   input  wire logic                    addr_bit20_mask_n_in,
   input  wire logic                    flush_n_in,
   input  wire logic                    wb_mode_in,
   input  wire logic                    acc_valid_in,
   input  wire logic                    acc_icache_in,
   input  wire logic                    acc_write_in,
   input  wire logic [`TLCCC_ADDR_W-1:0] acc_addr_in,
   output logic                         acc_ready_out,
   input  wire logic                    page_flush_invalidate_reg_wr_in,
   input  wire logic [`TLCCC_ADDR_W-`TLCCC_PAGE_LSB-1:0] page_in,
   input  wire logic                    page_inval_in,
   input  wire logic                    writeback_invalidate_instr_in,
   input  wire logic                    invalidate_all_instr_in,
   output logic                         busy_out,
   output logic                         op_done_out,
   output logic                         bus_req_out,
   output logic                         bus_write_out,
   output logic                         bus_burst_out,
   output logic [`TLCCC_ADDR_W-1:0]     bus_addr_out,
   input  wire logic                    bus_ack_in
);

   localparam int AW    = `TLCCC_ADDR_W;
   localparam int IDX_W = $clog2(LINES);
   localparam int TAG_W = AW - `TLCCC_LINE_LSB - IDX_W;
   localparam int PG_W  = AW - `TLCCC_PAGE_LSB;
   localparam logic [IDX_W-1:0] LAST = IDX_W'(LINES - 1);

   typedef struct packed {
      tlccc_pkg::tlccc_fsm_t                   fsm;
      tlccc_pkg::tlccc_mesi_t [LINES-1:0]      d_st;
      logic [LINES-1:0][TAG_W-1:0]             d_tag;
      tlccc_pkg::tlccc_mesi_t [LINES-1:0]      l2_st;
      logic [LINES-1:0][TAG_W-1:0]             l2_tag;
      tlccc_pkg::tlccc_ival_t [LINES-1:0]      i_st;
      logic [LINES-1:0][TAG_W-1:0]             i_tag;
      logic [IDX_W-1:0]                        idx;
      logic                                    walk_wb;
      logic                                    walk_page;
      logic [PG_W-1:0]                         page;
      logic                                    pend_flush;
      logic                                    pend_wbinv;
      logic                                    pend_inv;
      logic                                    pend_page;
      logic                                    pend_pinv;
      logic [PG_W-1:0]                         pend_addr;
      logic                                    flush_prev;
      logic                                    ret_walk;
      logic                                    op_done;
      logic                                    bus_req;
      logic                                    bus_write;
      logic                                    bus_burst;
      logic [AW-1:0]                           bus_addr;
   } tlccc_state_t;

   tlccc_state_t s_reg;
   tlccc_state_t s_next;

   logic a20_lvl;
   logic flush_lvl;

   function automatic logic [TAG_W-1:0] tag_of(input logic [AW-1:0] a);
      tag_of = a[AW-1 -: TAG_W];
   endfunction

   function automatic logic [IDX_W-1:0] idx_of(input logic [AW-1:0] a);
      idx_of = a[`TLCCC_LINE_LSB +: IDX_W];
   endfunction

   function automatic logic [AW-1:0] line_of(input logic [TAG_W-1:0] t,
                                             input logic [IDX_W-1:0] i);
      line_of = {t, i, {`TLCCC_LINE_LSB{1'b0}}};
   endfunction

   // page match of a line; the slice is taken on a local copy because a
   // function result cannot be part-selected
   function automatic logic in_page(input logic [TAG_W-1:0] t,
                                    input logic [IDX_W-1:0] i,
                                    input logic [PG_W-1:0]  p);
      logic [AW-1:0] la;
      la      = line_of(t, i);
      in_page = (la[AW-1:`TLCCC_PAGE_LSB] == p);
   endfunction

   // both pins come from outside the clock domain
   tlccc_sync #(.RESET_VAL(1'b1)) u_a20_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .pin_in     (addr_bit20_mask_n_in),
      .level_out  (a20_lvl)
   );

   tlccc_sync #(.RESET_VAL(1'b1)) u_flush_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .pin_in     (flush_n_in),
      .level_out  (flush_lvl)
   );

   // access decode; the mask sits ahead of every tag compare
   logic [AW-1:0]    a_addr;
   logic [IDX_W-1:0] ai;
   logic [TAG_W-1:0] at;
   logic             d_hit;
   logic             i_hit;
   logic             l2_hit;
   logic             any_pend;
   logic             victim_wb;

   assign a_addr = a20_lvl ? acc_addr_in
                 : (acc_addr_in & ~(AW'(1) << `TLCCC_A20_BIT));
   assign ai     = idx_of(a_addr);
   assign at     = tag_of(a_addr);
   assign d_hit  = (s_reg.d_st[ai] != tlccc_pkg::MESI_I)
                 && (s_reg.d_tag[ai] == at);
   assign i_hit  = (s_reg.i_st[ai] == tlccc_pkg::IC_VALID)
                 && (s_reg.i_tag[ai] == at);
   assign l2_hit = (s_reg.l2_st[ai] != tlccc_pkg::MESI_I)
                 && (s_reg.l2_tag[ai] == at);
   assign any_pend = s_reg.pend_flush | s_reg.pend_wbinv
                   | s_reg.pend_inv | s_reg.pend_page;

   // a dirty data line blocking a read fill, or hit by an instruction
   // miss snoop with no l2 copy, goes to the bus before the access
   assign victim_wb = acc_valid_in && !acc_write_in
                    && (s_reg.d_st[ai] == tlccc_pkg::MESI_M)
                    && ((!acc_icache_in && !d_hit)
                        || (acc_icache_in && !i_hit && d_hit && !l2_hit));

   assign acc_ready_out = (s_reg.fsm == tlccc_pkg::ST_IDLE)
                        && !any_pend && !victim_wb;

   // next-state logic for the whole controller
   always_comb begin
      logic          go;
      logic          go_wr;
      logic          go_burst;
      logic [AW-1:0] go_addr;
      logic          m_d;
      logic          m_2;
      logic          m_i;
      go       = 1'b0;
      go_wr    = 1'b0;
      go_burst = 1'b0;
      go_addr  = '0;
      m_d      = 1'b0;
      m_2      = 1'b0;
      m_i      = 1'b0;
      s_next   = s_reg;
      s_next.op_done    = 1'b0;
      s_next.flush_prev = flush_lvl;
      case (s_reg.fsm)
         tlccc_pkg::ST_IDLE: begin
            if (any_pend) begin
               // priority: flush pin, writeback-invalidate, invalidate, page
               s_next.fsm       = tlccc_pkg::ST_WALK;
               s_next.idx       = '0;
               s_next.walk_page = 1'b0;
               s_next.page      = s_reg.pend_addr;
               if (s_reg.pend_flush) begin
                  s_next.walk_wb    = 1'b1;
                  s_next.pend_flush = 1'b0;
               end else if (s_reg.pend_wbinv) begin
                  s_next.walk_wb    = 1'b1;
                  s_next.pend_wbinv = 1'b0;
               end else if (s_reg.pend_inv) begin
                  s_next.walk_wb    = 1'b0;
                  s_next.pend_inv   = 1'b0;
               end else begin
                  s_next.walk_wb    = !s_reg.pend_pinv;
                  s_next.walk_page  = 1'b1;
                  s_next.pend_page  = 1'b0;
               end
            end else if (victim_wb) begin
               go       = 1'b1;
               go_wr    = 1'b1;
               go_burst = 1'b1;
               go_addr  = line_of(s_reg.d_tag[ai], ai);
               s_next.d_st[ai] = tlccc_pkg::MESI_I;
            end else if (acc_valid_in && !acc_icache_in) begin
               if (i_hit) begin
                  s_next.i_st[ai] = tlccc_pkg::IC_INVALID;
               end
               if (acc_write_in) begin
                  if (d_hit && (s_reg.d_st[ai] == tlccc_pkg::MESI_M
                             || s_reg.d_st[ai] == tlccc_pkg::MESI_E)) begin
                     s_next.d_st[ai] = tlccc_pkg::MESI_M;
                  end else begin
                     go      = 1'b1;
                     go_wr   = 1'b1;
                     go_addr = a_addr;
                  end
               end else if (!d_hit) begin
                  s_next.d_tag[ai] = at;
                  // an l2 modified copy forces a shared data line
                  s_next.d_st[ai] = (wb_mode_in && !(l2_hit
                     && s_reg.l2_st[ai] == tlccc_pkg::MESI_M))
                     ? tlccc_pkg::MESI_E : tlccc_pkg::MESI_S;
                  if (!l2_hit) begin
                     go       = 1'b1;
                     go_burst = 1'b1;
                     go_addr  = line_of(at, ai);
                     if (s_reg.l2_st[ai] != tlccc_pkg::MESI_M) begin
                        s_next.l2_tag[ai] = at;
                        s_next.l2_st[ai]  = wb_mode_in ? tlccc_pkg::MESI_E
                                                       : tlccc_pkg::MESI_S;
                     end
                  end
               end
            end else if (acc_valid_in && !i_hit) begin
               // instruction read miss snoops the data cache only
               if (d_hit) begin
                  if (s_reg.d_st[ai] == tlccc_pkg::MESI_M) begin
                     s_next.l2_st[ai] = tlccc_pkg::MESI_M;
                  end
                  s_next.d_st[ai] = tlccc_pkg::MESI_I;
               end
               s_next.i_tag[ai] = at;
               s_next.i_st[ai]  = tlccc_pkg::IC_VALID;
               if (!l2_hit) begin
                  go       = 1'b1;
                  go_burst = 1'b1;
                  go_addr  = line_of(at, ai);
               end
            end
         end
         tlccc_pkg::ST_WALK: begin
            // lines outside the page are left alone on a page walk
            m_d = !s_reg.walk_page
                  || in_page(s_reg.d_tag[s_reg.idx], s_reg.idx, s_reg.page);
            m_2 = !s_reg.walk_page
                  || in_page(s_reg.l2_tag[s_reg.idx], s_reg.idx, s_reg.page);
            m_i = !s_reg.walk_page
                  || in_page(s_reg.i_tag[s_reg.idx], s_reg.idx, s_reg.page);
            if (s_reg.walk_wb && m_d
                && s_reg.d_st[s_reg.idx] == tlccc_pkg::MESI_M) begin
               go       = 1'b1;
               go_wr    = 1'b1;
               go_burst = 1'b1;
               go_addr  = line_of(s_reg.d_tag[s_reg.idx], s_reg.idx);
               s_next.d_st[s_reg.idx] = tlccc_pkg::MESI_I;
            end else if (s_reg.walk_wb && m_2
                && s_reg.l2_st[s_reg.idx] == tlccc_pkg::MESI_M) begin
               go       = 1'b1;
               go_wr    = 1'b1;
               go_burst = 1'b1;
               go_addr  = line_of(s_reg.l2_tag[s_reg.idx], s_reg.idx);
               s_next.l2_st[s_reg.idx] = tlccc_pkg::MESI_I;
            end else begin
               if (m_d) begin
                  s_next.d_st[s_reg.idx] = tlccc_pkg::MESI_I;
               end
               if (m_2) begin
                  s_next.l2_st[s_reg.idx] = tlccc_pkg::MESI_I;
               end
               if (m_i) begin
                  s_next.i_st[s_reg.idx] = tlccc_pkg::IC_INVALID;
               end
               if (s_reg.idx == LAST) begin
                  s_next.fsm     = tlccc_pkg::ST_IDLE;
                  s_next.op_done = 1'b1;
               end else begin
                  s_next.idx = s_reg.idx + 1'b1;
               end
            end
         end
         tlccc_pkg::ST_BUS: begin
            if (bus_ack_in) begin
               s_next.bus_req = 1'b0;
               s_next.fsm     = s_reg.ret_walk ? tlccc_pkg::ST_WALK
                                               : tlccc_pkg::ST_IDLE;
            end
         end
         default: begin
            s_next.fsm = tlccc_pkg::ST_IDLE;
         end
      endcase
      // one bus cycle at a time; the walk resumes the same index after it
      if (go) begin
         s_next.bus_req   = 1'b1;
         s_next.bus_write = go_wr;
         s_next.bus_burst = go_burst;
         s_next.bus_addr  = go_addr;
         s_next.ret_walk  = (s_reg.fsm == tlccc_pkg::ST_WALK);
         s_next.fsm       = tlccc_pkg::ST_BUS;
      end
      // requests are latched last so a new one beats its own clear
      if (!flush_lvl && s_reg.flush_prev) begin
         s_next.pend_flush = 1'b1;
      end
      if (writeback_invalidate_instr_in) begin
         s_next.pend_wbinv = 1'b1;
      end
      if (invalidate_all_instr_in) begin
         s_next.pend_inv = 1'b1;
      end
      if (page_flush_invalidate_reg_wr_in) begin
         s_next.pend_page = 1'b1;
         s_next.pend_pinv = page_inval_in;
         s_next.pend_addr = page_in;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_reg            <= '0;
         s_reg.flush_prev <= 1'b1;
      end else if (ce_in) begin
         s_reg <= s_next;
      end
   end

   assign busy_out      = (s_reg.fsm != tlccc_pkg::ST_IDLE) || any_pend;
   assign op_done_out   = s_reg.op_done;
   assign bus_req_out   = s_reg.bus_req;
   assign bus_write_out = s_reg.bus_write;
   assign bus_burst_out = s_reg.bus_burst;
   assign bus_addr_out  = s_reg.bus_addr;

endmodule

`default_nettype wire

// ==== rtl/tlccc_defs.svh ====
// constants shared by the cache coherency control block
// assumes byte addresses of 32 bits and 32-byte cache lines
`ifndef TLCCC_DEFS_SVH
`define TLCCC_DEFS_SVH

`define TLCCC_ADDR_W   32
`define TLCCC_LINE_LSB 5
`define TLCCC_PAGE_LSB 12
`define TLCCC_A20_BIT  20
`define TLCCC_LINES    8

`endif

// ==== rtl/tlccc_pkg.sv ====
// types shared by the cache coherency control block
// assumes nothing of its surroundings
package tlccc_pkg;

   // line state of the l1 data cache and the l2 cache
   typedef enum logic [1:0] {MESI_I, MESI_S, MESI_E, MESI_M} tlccc_mesi_t;

   // the l1 instruction cache keeps only a valid state
   typedef enum logic {IC_INVALID, IC_VALID} tlccc_ival_t;

   // controller sequencing
   typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_BUS} tlccc_fsm_t;

endpackage

// ==== rtl/tlccc_sync.sv ====
// three-stage synchroniser with an agreement filter for one pin
// assumes the pin is asynchronous to ref_clk_in
`timescale 1ns/100ps
`default_nettype none

module tlccc_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic ref_clk_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   input  wire logic pin_in,
   output logic      level_out
);

   typedef struct packed {
      logic [2:0] shift;
      logic       level;
   } tlccc_sync_t;

   tlccc_sync_t s_reg;
   tlccc_sync_t s_next;

   // the first stage feeds only the second; the filter compares
   // stages two and three so a glitch never reaches the level
   always_comb begin
      s_next = s_reg;
      s_next.shift = {s_reg.shift[1:0], pin_in};
      if (s_reg.shift[2] == s_reg.shift[1]) begin
         s_next.level = s_reg.shift[2];
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_reg <= {{3{RESET_VAL}}, RESET_VAL};
      end else if (ce_in) begin
         s_reg <= s_next;
      end
   end

   assign level_out = s_reg.level;

endmodule

`default_nettype wire

// ==== testbench/tlccc_bus_model.sv ====
// system bus side: answers each cycle and counts reads and writes
// assumes one request at a time, held until the answer edge
`timescale 1ns/100ps
`default_nettype none

module tlccc_bus_model (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   input  wire logic        slow_in,
   input  wire logic        bus_req_in,
   input  wire logic        bus_write_in,
   input  wire logic        bus_burst_in,
   input  wire logic [31:0] bus_addr_in,
   output logic             bus_ack_out,
   output int               wr_cnt_out,
   output int               rd_cnt_out,
   output logic [31:0]      last_addr_out,
   output logic             last_burst_out
);
   int wait_cnt;

   // answer at once or after five wait cycles; the answer lasts one edge
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bus_ack_out <= 1'b0;
         wait_cnt <= 0;
         wr_cnt_out <= 0;
         rd_cnt_out <= 0;
         last_addr_out <= 32'h0;
         last_burst_out <= 1'b0;
      end else if (bus_ack_out) begin
         bus_ack_out <= 1'b0;
         wait_cnt <= 0;
      end else if (bus_req_in && wait_cnt >= (slow_in ? 5 : 0)) begin
         bus_ack_out <= 1'b1;
         last_addr_out <= bus_addr_in;
         last_burst_out <= bus_burst_in;
         if (bus_write_in) wr_cnt_out <= wr_cnt_out + 1;
         else rd_cnt_out <= rd_cnt_out + 1;
      end else if (bus_req_in) begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/tlccc_ctrl_props.sv ====
// assertions on the ports of the coherency control block
// assumes it is bound into tlccc_ctrl and that pins pass a short filter
`include "tlccc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tlccc_ctrl_props #(
   parameter int LINES = 8
) (
   input wire logic                     ref_clk_in,
   input wire logic                     rst_in,
   input wire logic                     ce_in,
   input wire logic                     addr_bit20_mask_n_in,
   input wire logic                     acc_valid_in,
   input wire logic                     acc_ready_out,
   input wire logic                     page_flush_invalidate_reg_wr_in,
   input wire logic                     page_inval_in,
   input wire logic                     invalidate_all_instr_in,
   input wire logic                     busy_out,
   input wire logic                     op_done_out,
   input wire logic                     bus_req_out,
   input wire logic                     bus_write_out,
   input wire logic                     bus_burst_out,
   input wire logic [`TLCCC_ADDR_W-1:0] bus_addr_out,
   input wire logic                     bus_ack_in
);
   logic [2:0] low_cnt_reg;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   // cycles the mask pin has been low; saturates so the filter has settled
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) low_cnt_reg <= 3'h0;
      else if (addr_bit20_mask_n_in) low_cnt_reg <= 3'h0;
      else if (low_cnt_reg != 3'h7) low_cnt_reg <= low_cnt_reg + 3'h1;
   end

   property p_burst_line;
      bus_req_out && bus_burst_out |-> bus_addr_out[4:0] == 5'h00;
   endproperty
   a_burst_line: assert property (p_burst_line)
      else $error("burst cycle not on a line boundary");

   property p_single_wr;
      bus_req_out && !bus_burst_out |-> bus_write_out;
   endproperty
   a_single_wr: assert property (p_single_wr)
      else $error("single cycle that is not a writethrough");

   property p_hold;
      bus_req_out && !bus_ack_in |=> bus_req_out && $stable(bus_addr_out)
         && $stable(bus_burst_out) && $stable(bus_write_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("bus cycle changed before its answer");

   property p_fill_mask;
      $rose(bus_req_out) && !bus_write_out && low_cnt_reg == 3'h7
         |-> !bus_addr_out[20];
   endproperty
   a_fill_mask: assert property (p_fill_mask)
      else $error("line fill kept address bit 20 under mask");

   property p_wt_mask;
      $rose(bus_req_out) && bus_write_out && !bus_burst_out
         && low_cnt_reg == 3'h7 |-> !bus_addr_out[20];
   endproperty
   a_wt_mask: assert property (p_wt_mask)
      else $error("writethrough kept address bit 20 under mask");

   property p_hold_off;
      busy_out || bus_req_out |-> !acc_ready_out;
   endproperty
   a_hold_off: assert property (p_hold_off)
      else $error("access accepted during maintenance");

   property p_invalidate_all_instr;
      LINES == 8 && ce_in && invalidate_all_instr_in && !busy_out
         && !bus_req_out && !acc_valid_in |=> !bus_req_out [*8] ##2 op_done_out;
   endproperty
   a_invalidate_all_instr: assert property (p_invalidate_all_instr)
      else $error("invalidate-all used the bus or ran long");

   property p_page_inv;
      ce_in && page_flush_invalidate_reg_wr_in && page_inval_in && !busy_out
         && !bus_req_out && !acc_valid_in |=> !bus_req_out [*8];
   endproperty
   a_page_inv: assert property (p_page_inv)
      else $error("page invalidate used the bus");
endmodule

bind tlccc_ctrl tlccc_ctrl_props #(.LINES(LINES)) u_props (.ref_clk_in,
   .rst_in, .ce_in, .addr_bit20_mask_n_in, .acc_valid_in, .acc_ready_out,
   .page_flush_invalidate_reg_wr_in, .page_inval_in,
   .invalidate_all_instr_in, .busy_out, .op_done_out, .bus_req_out,
   .bus_write_out, .bus_burst_out, .bus_addr_out, .bus_ack_in);
`default_nettype wire

// ==== testbench/tlccc_ctrl_test.sv ====
// testbench for the coherency control block with a bus side model
// assumes the default of eight lines and a 50 MHz clock
`include "tlccc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tlccc_ctrl_test;
   logic ref_clk_in = 0, rst_in = 1, ce_in = 1, slow = 0;
   logic addr_bit20_mask_n_in = 1, flush_n_in = 1, wb_mode_in = 0;
   logic acc_valid_in = 0, acc_icache_in = 0, acc_write_in = 0;
   logic [31:0] acc_addr_in = 32'h0, last_addr;
   logic acc_ready_out, busy_out, op_done_out, bus_req_out, last_burst;
   logic page_flush_invalidate_reg_wr_in = 0, page_inval_in = 0;
   logic [19:0] page_in = 20'h0;
   logic writeback_invalidate_instr_in = 0, invalidate_all_instr_in = 0;
   logic bus_write_out, bus_burst_out, bus_ack_in;
   logic [31:0] bus_addr_out;
   int error_cnt = 0, checked = 0, wr, rd, w0, r0, k;
   int exp_wr[5] = '{0, 0, 1, 1, 1};

   tlccc_ctrl dut (.ref_clk_in, .rst_in, .ce_in, .addr_bit20_mask_n_in,
      .flush_n_in, .wb_mode_in, .acc_valid_in, .acc_icache_in,
      .acc_write_in, .acc_addr_in, .acc_ready_out,
      .page_flush_invalidate_reg_wr_in, .page_in, .page_inval_in,
      .writeback_invalidate_instr_in, .invalidate_all_instr_in, .busy_out,
      .op_done_out, .bus_req_out, .bus_write_out, .bus_burst_out,
      .bus_addr_out, .bus_ack_in);

   tlccc_bus_model u_bus (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .slow_in(slow), .bus_req_in(bus_req_out), .bus_write_in(bus_write_out),
      .bus_burst_in(bus_burst_out), .bus_addr_in(bus_addr_out),
      .bus_ack_out(bus_ack_in), .wr_cnt_out(wr), .rd_cnt_out(rd),
      .last_addr_out(last_addr), .last_burst_out(last_burst));

   always #10 ref_clk_in = ~ref_clk_in;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      if (error_cnt == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // idle means three quiet cycles, so a gap between two bus cycles is
   // not taken for the end of an access
   task automatic wait_quiet;
      int i, q;
      q = 0;
      for (i = 0; i < 400 && q < 3; i++) begin
         @(negedge ref_clk_in);
         if (busy_out === 1'b0 && bus_req_out === 1'b0 && acc_ready_out) q++;
         else q = 0;
      end
      if (q < 3) begin error_cnt++; end_sim(); end
   endtask

   task automatic access(input logic ic, wr_en, wb, input logic [31:0] a);
      int i;
      acc_valid_in = 1;
      acc_icache_in = ic;
      acc_write_in = wr_en;
      wb_mode_in = wb;
      acc_addr_in = a;
      for (i = 0; i < 400 && acc_ready_out !== 1'b1; i++)
         @(negedge ref_clk_in);
      if (i == 400) begin error_cnt++; end_sim(); end
      @(negedge ref_clk_in);
      acc_valid_in = 0;
      wait_quiet();
   endtask

   // kinds: 0 invalidate-all, 1 page invalidate, 2 page flush,
   // 3 flush pin, 4 writeback-invalidate
   task automatic do_op(input int kind);
      int i;
      flush_n_in = (kind != 3);
      writeback_invalidate_instr_in = (kind == 4);
      invalidate_all_instr_in = (kind == 0);
      page_flush_invalidate_reg_wr_in = (kind == 1 || kind == 2);
      page_inval_in = (kind == 1);
      @(negedge ref_clk_in);
      writeback_invalidate_instr_in = 0;
      invalidate_all_instr_in = 0;
      page_flush_invalidate_reg_wr_in = 0;
      repeat (6) @(negedge ref_clk_in);
      flush_n_in = 1;
      for (i = 0; i < 400 && op_done_out !== 1'b1; i++)
         @(negedge ref_clk_in);
      if (i == 400) begin error_cnt++; end_sim(); end
      wait_quiet();
   endtask

   task automatic t_reset;
      chk(busy_out, 1'b0);
      chk(bus_req_out, 1'b0);
      chk(acc_ready_out, 1'b1);
   endtask

   task automatic t_mask;
      addr_bit20_mask_n_in = 0;
      repeat (8) @(negedge ref_clk_in);
      r0 = rd;
      access(0, 0, 0, 32'h0010_0040);
      chk(rd - r0, 1);
      chk(last_addr, 32'h0000_0040);
      chk(last_burst, 1'b1);
      w0 = wr;
      access(0, 1, 0, 32'h0010_0044);
      chk(wr - w0, 1);
      chk(last_addr, 32'h0000_0044);
      chk(last_burst, 1'b0);
      addr_bit20_mask_n_in = 1;
      repeat (8) @(negedge ref_clk_in);
      access(0, 0, 0, 32'h0010_0060);
      chk(last_addr, 32'h0010_0060);
   endtask

   task automatic t_wback;
      access(0, 0, 1, 32'h0010_0080);
      w0 = wr;
      access(0, 1, 1, 32'h0010_0084);
      chk(wr - w0, 0);
      do_op(2);
      chk(wr - w0, 0);
      addr_bit20_mask_n_in = 0;
      repeat (8) @(negedge ref_clk_in);
      do_op(4);
      chk(wr - w0, 1);
      chk(last_addr, 32'h0010_0080);
      chk(last_burst, 1'b1);
      addr_bit20_mask_n_in = 1;
      repeat (8) @(negedge ref_clk_in);
   endtask

   // a dirty line under each maintenance kind, with a slow bus side
   task automatic t_maint;
      slow = 1;
      for (k = 0; k < 5; k++) begin
         r0 = rd;
         w0 = wr;
         access(0, 0, 1, 32'h0000_00c0);
         chk(rd - r0, 1);
         access(0, 1, 1, 32'h0000_00c4);
         do_op(k);
         chk(wr - w0, exp_wr[k]);
         if (exp_wr[k] == 1) chk(last_addr, 32'h0000_00c0);
      end
      slow = 0;
   endtask

   task automatic t_snoop;
      access(0, 0, 1, 32'h0000_0100);
      access(0, 1, 1, 32'h0000_0104);
      r0 = rd;
      w0 = wr;
      access(1, 0, 0, 32'h0000_0100);
      chk(wr - w0, 0);
      chk(rd - r0, 0);
      // same index, other line: l2 keeps its dirty line, so this snoop
      // finds no l2 copy and must send the data line to the bus
      access(0, 0, 1, 32'h0000_0200);
      access(0, 1, 1, 32'h0000_0204);
      w0 = wr;
      access(1, 0, 0, 32'h0000_0200);
      chk(wr - w0, 1);
      do_op(4);
      chk(wr - w0, 2);
      chk(last_addr, 32'h0000_0100);
   endtask

   // a request that arrives while the clock enable is low is not seen
   task automatic t_freeze;
      ce_in = 0;
      invalidate_all_instr_in = 1;
      @(negedge ref_clk_in);
      invalidate_all_instr_in = 0;
      ce_in = 1;
      repeat (2) @(negedge ref_clk_in);
      chk(busy_out, 1'b0);
   endtask

   initial begin
      repeat (16) @(negedge ref_clk_in);
      rst_in = 0;
      @(negedge ref_clk_in);
      t_reset();
      t_freeze();
      t_mask();
      t_wback();
      t_maint();
      t_snoop();
      end_sim();
   end
endmodule
`default_nettype wire
